/* src/mmp_top.sv */
// Management sideband of a pluggable transceiver: select, reset, low power,
// presence, open-collector interrupt and a two-wire slave onto a small map.
// Assumes host pull-ups on the serial data and interrupt lines.
//
// Function
// R1: Serial commands are answered only while module select is held low.
// R2: Host gives each module its own select and lowers one at a time.
// R3: Reset pin low beyond minimum pulse restores all settings to defaults.
// R4: Host ignores status bits until reset completion is signalled.
// R5: Completion shown by interrupt with the not-ready flag cleared.
// R6: Power-up posts the completion interrupt without any reset pulse.
// R7: Low power select limits the module's maximum power draw.
// R8: Presence line is tied to ground while the module is inserted.
// R9: Interrupt pulled low on fault or critical status.
// R10: Host reads the map over the serial bus to find the source.
// R11: Interrupt only pulls low or releases, never drives high.
// R12: Serial clock and data carry every access to the memory map.
// R13: Minimum reset pulse is a parameter; shorter low pulses are ignored.
`timescale 1ns/100ps
`default_nettype none
module mmp_top #(
    parameter int         RST_MIN_NS = 10000,
    parameter int         INIT_MS    = 2000,
    parameter logic [6:0] DEV_ADDR   = 7'h50
)(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Two-wire serial link
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var  logic sda_o,
    output var  logic sda_oe_n_o,
    // Sideband pins
    input  wire logic module_select_n_i,
    input  wire logic module_reset_n_i,
    input  wire logic low_power_select_i,
    output var  logic module_present_n_o,
    output var  logic module_irq_n_o,
    output var  logic module_irq_oe_n_o,
    // Internal module logic
    input  wire logic fault_i,
    input  wire logic status_crit_i,
    output var  logic power_limit_o,
    output var  logic settings_reset_o
);

    // ****************************************************************
    // Derived timing
    // ****************************************************************
    localparam int RST_MIN_CYC = (RST_MIN_NS + mmp_pkg::CLK_PERIOD_NS - 1)
                                 / mmp_pkg::CLK_PERIOD_NS;
    localparam int INIT_CYC_RAW = INIT_MS * (mmp_pkg::NS_PER_MS / mmp_pkg::CLK_PERIOD_NS);
    localparam int INIT_CYC    = (INIT_CYC_RAW < 1) ? 1 : INIT_CYC_RAW;
    localparam int INIT_W      = $clog2(INIT_CYC + 1);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    mmp_pkg::mmp_pins_t pins_raw;
    mmp_pkg::mmp_pins_t pins_s;
    mmp_pkg::mmp_state_t state_q;

    logic              pin_rst;
    logic              core_rst;
    logic              scl_q;
    logic              sda_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_evt;
    logic              stop_evt;
    logic              selected;
    logic [INIT_W-1:0] init_cnt_q;
    logic              not_ready_q;
    logic              ready_evt;
    logic [7:0]        flags_q;
    logic [7:0]        flags_set;
    logic [7:0]        flags_clr;
    logic [7:0]        status_byte;
    logic [7:0]        rd_data;
    logic [7:0]        rx_shift_q;
    logic [7:0]        tx_q;
    logic [2:0]        bit_cnt_q;
    logic [2:0]        ptr_q;
    logic              done_q;
    logic              rw_q;
    logic              ptr_set_q;
    logic              ack_ok_q;
    logic              tx_load;
    logic              wr_en;
    logic [7:0]        rw_q_map [mmp_pkg::MAP_FIRST_RW:mmp_pkg::MAP_DEPTH-1];

    // ****************************************************************
    // Pin synchronisers and reset filter
    // ****************************************************************
    assign pins_raw = '{sda:   sda_i,
                        scl:   scl_i,
                        sel_n: module_select_n_i,
                        rst_n: module_reset_n_i,
                        lp:    low_power_select_i};

    mmp_sync #(
        .W   ($bits(mmp_pkg::mmp_pins_t)),
        .RST (mmp_pkg::PINS_RST)
    ) u_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (pins_raw),
        .sync_o  (pins_s)
    );

    mmp_rst_filter #(
        .MIN_CYC (RST_MIN_CYC)
    ) u_rst_filter (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .pin_n_i (pins_s.rst_n),
        .hold_o  (pin_rst)
    );

    // Power-up and a filtered pin reset both restore defaults
    assign core_rst = !nrst_i || pin_rst; // R3

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            settings_reset_o <= 1'b1;
        end else begin
            settings_reset_o <= pin_rst;
        end
    end

    // ****************************************************************
    // Link domain: bit capture on the host's serial clock
    // ****************************************************************
    // Only data lives here; framing is decoded in the core domain
    always_ff @(posedge scl_i) begin
        rx_shift_q <= {rx_shift_q[6:0], sda_i}; // R12
    end

    // ****************************************************************
    // Line events
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= pins_s.scl;
            sda_q <= pins_s.sda;
        end
    end

    assign scl_rise  = pins_s.scl && !scl_q;
    assign scl_fall  = !pins_s.scl && scl_q;
    assign start_evt = pins_s.scl && scl_q && sda_q && !pins_s.sda;
    assign stop_evt  = pins_s.scl && scl_q && !sda_q && pins_s.sda;
    assign selected  = !pins_s.sel_n;

    // ****************************************************************
    // Initialisation and readiness
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            init_cnt_q  <= '0;
            not_ready_q <= 1'b1;
        end else if (ready_evt) begin
            not_ready_q <= 1'b0; // R6
        end else if (not_ready_q) begin
            init_cnt_q  <= init_cnt_q + 1'b1;
        end
    end

    assign ready_evt = not_ready_q && (init_cnt_q == INIT_W'(INIT_CYC - 1));

    // ****************************************************************
    // Sticky flags, cleared by reading them
    // ****************************************************************
    always_comb begin
        flags_set = mmp_pkg::BYTE_ZERO;
        flags_set[mmp_pkg::FL_RESET_DONE] = ready_evt; // R5
        flags_set[mmp_pkg::FL_FAULT]      = fault_i; // R9
        flags_set[mmp_pkg::FL_CRIT]       = status_crit_i; // R9
        flags_clr = (tx_load && ptr_q == mmp_pkg::IDX_FLAGS) ? rd_data
                                                             : mmp_pkg::BYTE_ZERO;
    end

    // Set beats clear so an event during the read is kept
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            flags_q <= mmp_pkg::MAP_RST;
        end else begin
            flags_q <= (flags_q & ~flags_clr) | flags_set;
        end
    end

    // ****************************************************************
    // Memory map storage and read mux
    // ****************************************************************
    assign wr_en = (state_q == mmp_pkg::ST_RX) && scl_rise
                   && (bit_cnt_q == mmp_pkg::BIT_LAST) && ptr_set_q;

    for (genvar g = mmp_pkg::MAP_FIRST_RW; g < mmp_pkg::MAP_DEPTH; g++) begin : g_map
        always_ff @(posedge clk_i) begin
            if (core_rst) begin
                rw_q_map[g] <= mmp_pkg::MAP_RST; // R3
            end else if (wr_en && (ptr_q == 3'(g))) begin
                // Word is stable: next serial edge is microseconds away
                rw_q_map[g] <= rx_shift_q; // R12
            end
        end
    end

    always_comb begin
        status_byte = mmp_pkg::BYTE_ZERO;
        status_byte[mmp_pkg::ST_NOT_READY] = not_ready_q;
        status_byte[mmp_pkg::ST_LOW_POWER] = power_limit_o;
        if (ptr_q == mmp_pkg::IDX_STATUS) begin
            rd_data = status_byte;
        end else if (ptr_q == mmp_pkg::IDX_FLAGS) begin
            rd_data = flags_q; // R10
        end else begin
            rd_data = rw_q_map[ptr_q];
        end
    end

    // ****************************************************************
    // Serial slave engine
    // ****************************************************************
    assign tx_load = scl_fall && (((state_q == mmp_pkg::ST_ADDR_ACK) && rw_q)
                     || ((state_q == mmp_pkg::ST_TX_ACK) && ack_ok_q));

    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            state_q    <= mmp_pkg::ST_IDLE;
            bit_cnt_q  <= mmp_pkg::BIT_FIRST;
            done_q     <= 1'b0;
            rw_q       <= 1'b0;
            ptr_set_q  <= 1'b0;
            ptr_q      <= mmp_pkg::IDX_STATUS;
            ack_ok_q   <= 1'b0;
            tx_q       <= mmp_pkg::BYTE_ZERO;
            sda_oe_n_o <= 1'b1;
        end else if (!selected || stop_evt) begin
            // Deselected modules leave the bus untouched
            state_q    <= mmp_pkg::ST_IDLE; // R1
            sda_oe_n_o <= 1'b1;
            done_q     <= 1'b0;
        end else if (start_evt) begin
            state_q    <= mmp_pkg::ST_ADDR; // R1
            bit_cnt_q  <= mmp_pkg::BIT_FIRST;
            done_q     <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            unique case (state_q)
                mmp_pkg::ST_IDLE: begin
                    sda_oe_n_o <= 1'b1;
                end
                mmp_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        if (bit_cnt_q == mmp_pkg::BIT_LAST) begin
                            if (rx_shift_q[7:1] == DEV_ADDR) begin
                                done_q <= 1'b1;
                                rw_q   <= rx_shift_q[0];
                            end else begin
                                state_q <= mmp_pkg::ST_IDLE;
                            end
                        end
                    end else if (scl_fall && done_q) begin
                        sda_oe_n_o <= 1'b0;
                        done_q     <= 1'b0;
                        bit_cnt_q  <= mmp_pkg::BIT_FIRST;
                        state_q    <= mmp_pkg::ST_ADDR_ACK;
                    end
                end
                mmp_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            sda_oe_n_o <= rd_data[7];
                            tx_q       <= {rd_data[6:0], 1'b1};
                            ptr_q      <= ptr_q + 1'b1;
                            state_q    <= mmp_pkg::ST_TX;
                        end else begin
                            sda_oe_n_o <= 1'b1;
                            ptr_set_q  <= 1'b0;
                            state_q    <= mmp_pkg::ST_RX;
                        end
                    end
                end
                mmp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        if (bit_cnt_q == mmp_pkg::BIT_LAST) begin
                            done_q <= 1'b1;
                            if (!ptr_set_q) begin
                                ptr_q     <= rx_shift_q[2:0];
                                ptr_set_q <= 1'b1;
                            end else begin
                                ptr_q <= ptr_q + 1'b1;
                            end
                        end
                    end else if (scl_fall && done_q) begin
                        sda_oe_n_o <= 1'b0;
                        done_q     <= 1'b0;
                        bit_cnt_q  <= mmp_pkg::BIT_FIRST;
                        state_q    <= mmp_pkg::ST_RX_ACK;
                    end
                end
                mmp_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n_o <= 1'b1;
                        state_q    <= mmp_pkg::ST_RX;
                    end
                end
                mmp_pkg::ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        if (bit_cnt_q == mmp_pkg::BIT_LAST) begin
                            done_q <= 1'b1;
                        end
                    end else if (scl_fall) begin
                        if (done_q) begin
                            sda_oe_n_o <= 1'b1;
                            done_q     <= 1'b0;
                            bit_cnt_q  <= mmp_pkg::BIT_FIRST;
                            state_q    <= mmp_pkg::ST_TX_ACK;
                        end else begin
                            // Open drain: a one is sent by releasing
                            sda_oe_n_o <= tx_q[7]; // R12
                            tx_q       <= {tx_q[6:0], 1'b1};
                        end
                    end
                end
                mmp_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_ok_q <= !pins_s.sda;
                    end else if (scl_fall) begin
                        if (ack_ok_q) begin
                            sda_oe_n_o <= rd_data[7];
                            tx_q       <= {rd_data[6:0], 1'b1};
                            ptr_q      <= ptr_q + 1'b1;
                            state_q    <= mmp_pkg::ST_TX;
                        end else begin
                            state_q <= mmp_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Sideband outputs
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            power_limit_o <= 1'b1;
        end else begin
            power_limit_o <= pins_s.lp
                             || rw_q_map[mmp_pkg::IDX_CTRL][mmp_pkg::CTRL_FORCE_LP]; // R7
        end
    end

    // Held off while not ready so stale status is never flagged
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            module_irq_oe_n_o <= 1'b1;
        end else begin
            module_irq_oe_n_o <= !(!not_ready_q
                && |(flags_q & ~rw_q_map[mmp_pkg::IDX_MASK])); // R5 R9
        end
    end

    // Data levels are constant low: only the enables move
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            module_irq_n_o     <= 1'b0;
            module_present_n_o <= 1'b0;
            sda_o              <= 1'b0;
        end else begin
            module_irq_n_o     <= 1'b0; // R11
            module_present_n_o <= 1'b0; // R8
            sda_o              <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* src/mmp_pkg.sv */
// Shared constants, types and memory map layout of the management pins.
// Assumes a 40 MHz core clock; the serial clock comes from the host.
package mmp_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_MS     = 1_000_000;

    // ****************************************************************
    // Memory map
    // ****************************************************************
    localparam int          MAP_DEPTH    = 8;
    localparam int          MAP_FIRST_RW = 2;
    localparam logic [2:0]  IDX_STATUS   = 3'h0;
    localparam logic [2:0]  IDX_FLAGS    = 3'h1;
    localparam logic [2:0]  IDX_MASK     = 3'h2;
    localparam logic [2:0]  IDX_CTRL     = 3'h3;
    localparam logic [7:0]  MAP_RST      = 8'h00;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;

    // Status byte fields
    localparam int ST_NOT_READY  = 0;
    localparam int ST_LOW_POWER  = 1;

    // Flag byte fields
    localparam int FL_RESET_DONE = 0;
    localparam int FL_FAULT      = 1;
    localparam int FL_CRIT       = 2;

    // Control byte fields
    localparam int CTRL_FORCE_LP = 0;

    // ****************************************************************
    // Serial engine
    // ****************************************************************
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [4:0] PINS_RST  = 5'h1f;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } mmp_state_t;

    typedef struct packed {
        logic sda;
        logic scl;
        logic sel_n;
        logic rst_n;
        logic lp;
    } mmp_pins_t;

endpackage

/* src/mmp_sync.sv */
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module mmp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
)(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);

    // ****************************************************************
    // Per-bit stages
    // ****************************************************************
    logic [W-1:0] meta_q;

    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                meta_q[g] <= RST[g];
                sync_o[g] <= RST[g];
            end else begin
                meta_q[g] <= async_i[g];
                sync_o[g] <= meta_q[g];
            end
        end
    end

endmodule
`default_nettype wire

/* src/mmp_rst_filter.sv */
// Pulse-length filter on the synchronised module reset pin.
// Assumes its input is already synchronised to clk_i.
`timescale 1ns/100ps
`default_nettype none
module mmp_rst_filter #(
    parameter int MIN_CYC = 1
)(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Pin level and filtered reset
    input  wire logic pin_n_i,
    output var  logic hold_o
);

    // ****************************************************************
    // Low-time counter
    // ****************************************************************
    localparam int CW = $clog2(MIN_CYC + 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_q  <= '0;
            hold_o <= 1'b0;
        end else if (pin_n_i) begin
            // Short glitches never reach the threshold
            cnt_q  <= '0; // R13
            hold_o <= 1'b0;
        end else if (cnt_q == CW'(MIN_CYC)) begin
            // Stays in reset for as long as the pin stays low
            hold_o <= 1'b1; // R3
        end else begin
            cnt_q  <= cnt_q + 1'b1;
        end
    end

endmodule
`default_nettype wire

/* test/mmp_assertions.sv */
// Pin-level checker for the management sideband top module.
// Assumes it is bound to mmp_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module mmp_assertions #(
    parameter int RST_MIN_NS = 10000,
    parameter int INIT_MS    = 2000
)(
    // Clock, reset and pins
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sda_oe_n_o,
    input wire logic module_select_n_i,
    input wire logic module_reset_n_i,
    input wire logic low_power_select_i,
    input wire logic module_present_n_o,
    input wire logic module_irq_n_o,
    input wire logic module_irq_oe_n_o,
    input wire logic power_limit_o,
    input wire logic settings_reset_o
);
    localparam int MIN_CYC   = (RST_MIN_NS + 24) / 25;
    localparam int LONG_CYC  = MIN_CYC + 8;
    // Only usable while the init time is cut down
    localparam int INIT_WAIT = INIT_MS * 40000 + 8;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_present; module_present_n_o == 1'b0; endproperty
    a_present: assert property (p_present) else $error("presence not grounded");
    property p_irq_od; module_irq_n_o == 1'b0; endproperty
    a_irq_od: assert property (p_irq_od) else $error("irq data high");
    property p_desel; module_select_n_i [*8] |-> sda_oe_n_o; endproperty
    a_desel: assert property (p_desel) else $error("drives data unselected");
    property p_short; $rose(settings_reset_o) |-> !$past(module_reset_n_i, MIN_CYC); endproperty
    a_short: assert property (p_short) else $error("short reset pulse taken");
    property p_long; $fell(module_reset_n_i) |-> ##[1:LONG_CYC] (settings_reset_o || module_reset_n_i); endproperty
    a_long: assert property (p_long) else $error("long reset pulse missed");
    property p_rst_irq; settings_reset_o [*2] |-> module_irq_oe_n_o; endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("irq during reset");
    property p_irq_cause; $fell(module_irq_oe_n_o) |-> !settings_reset_o; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq raised in reset");
    property p_init; $fell(settings_reset_o) |-> ##[1:INIT_WAIT] !module_irq_oe_n_o; endproperty
    a_init: assert property (p_init) else $error("no completion irq");
    property p_power; low_power_select_i [*5] |-> power_limit_o; endproperty
    a_power: assert property (p_power) else $error("power not limited");
endmodule
bind mmp_top mmp_assertions #(.RST_MIN_NS(RST_MIN_NS), .INIT_MS(INIT_MS)) u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .sda_oe_n_o(sda_oe_n_o),
    .module_select_n_i(module_select_n_i), .module_reset_n_i(module_reset_n_i),
    .low_power_select_i(low_power_select_i), .module_present_n_o(module_present_n_o),
    .module_irq_n_o(module_irq_n_o), .module_irq_oe_n_o(module_irq_oe_n_o),
    .power_limit_o(power_limit_o), .settings_reset_o(settings_reset_o)
);
`default_nettype wire

/* test/mmp_host.sv */
// Host management controller model: two-wire master with open-drain drive.
// Assumes the bench resolves SDA with a pull-up; SCL stands high when idle.
`timescale 1ns/100ps
`default_nettype none
module mmp_host (
    // Link clock, resolved data line and drives (1 = released)
    input  wire logic lclk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_o
);
    initial {scl_o, sda_o} = 2'b11;
    // Third of a bit of twelve link cycles, slow enough for the synced engine
    task automatic step(input logic c, input logic d);
        @(posedge lclk_i);
        {scl_o, sda_o} = {c, d};
        repeat (11) @(posedge lclk_i);
    endtask
    // Start when s is high, stop otherwise; every access is framed here
    task automatic cond(input logic s);
        step(1'b0, sda_o);
        step(1'b0, s);
        step(1'b1, s);
        step(1'b1, !s);
    endtask
    // Eight bits MSB first plus the acknowledge slot
    task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, sda_o);
            step(1'b0, d[i]);
            step(1'b1, d[i]);
            q[i] = sda_i;
        end
    endtask
endmodule
`default_nettype wire

/* test/tb_module_management_pins.sv */
// Self-checking bench of the management sideband with a host model.
// Assumes a shortened reset filter and init time in the design.
`timescale 1ns/100ps
`default_nettype none
module tb_module_management_pins;
    localparam logic [6:0] DEV = 7'h50;
    logic clk_i = 1'b0, lclk = 1'b0, nrst_i = 1'b0, rd_v = 1'b0;
    logic sel_n = 1'b0, rst_n = 1'b1, lp = 1'b0, fault = 1'b0, crit = 1'b0;
    logic scl, sda_h, sda_d, oe_n, pres_n, irq_n, irq_oe_n, plim, srst;
    logic [7:0] rd_d;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int samples_checked = 0;
    wire sda_w = sda_h & (oe_n | sda_d);
    always #12.5 clk_i = ~clk_i;
    always #7.5 lclk = ~lclk;
    mmp_top #(.RST_MIN_NS(200), .INIT_MS(0), .DEV_ADDR(DEV)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
        .sda_oe_n_o(oe_n), .module_select_n_i(sel_n), .module_reset_n_i(rst_n),
        .low_power_select_i(lp), .module_present_n_o(pres_n), .module_irq_n_o(irq_n),
        .module_irq_oe_n_o(irq_oe_n), .fault_i(fault), .status_crit_i(crit),
        .power_limit_o(plim), .settings_reset_o(srst)
    );
    mmp_host host (.lclk_i(lclk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
    always @(posedge clk_i) if (rd_v) chk("read byte", exp_q.pop_front(), rd_d);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) error_cnt++;
        if (s !== e) $display("wrong value %s: expected %h, seen %h", nm, e, s);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // One framed access; on a read d is the expected byte
    task automatic acc(input logic [2:0] ix, input logic [7:0] d, input logic rd, input logic ea);
        logic [8:0] q;
        host.cond(1'b1);
        host.xbyte({DEV, 2'b01}, q);
        chk("address ack", {7'h0, ea}, {7'h0, q[0]});
        host.xbyte({5'h0, ix, 1'b1}, q);
        if (rd) host.cond(1'b1);
        if (rd) host.xbyte({DEV, 2'b11}, q);
        host.xbyte(rd ? 9'h1ff : {d, 1'b1}, q);
        host.cond(1'b0);
        cyc(1);
        if (rd) exp_q.push_back(d);
        rd_d = q[8:1];
        rd_v = rd;
        cyc(1);
        rd_v = 1'b0;
    endtask
    task automatic wt(input logic v);
        int n;
        for (n = 0; n < 500 && irq_oe_n !== v; n++) cyc(1);
        chk("interrupt", {7'h0, v}, {7'h0, irq_oe_n});
        if (n == 500) give_verdict();
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        logic [7:0] c;
        void'($urandom(32'h62a82d63));
        cyc(10);
        nrst_i = 1'b1;
        wt(1'b0);
        chk("presence", 8'h00, {7'h0, pres_n});
        chk("irq data", 8'h00, {7'h0, irq_n});
        acc(mmp_pkg::IDX_STATUS, 8'h00, 1'b1, 1'b0);
        acc(mmp_pkg::IDX_FLAGS, 8'h01, 1'b1, 1'b0);
        wt(1'b1);
        $display("test power-up over");
        repeat (4) begin
            lp = 1'($urandom);
            c = {7'h0, 1'($urandom)};
            acc(mmp_pkg::IDX_CTRL, c, 1'b0, 1'b0);
            chk("power limit", {7'h0, lp | c[0]}, {7'h0, plim});
            acc(mmp_pkg::IDX_STATUS, {6'h0, lp | c[0], 1'b0}, 1'b1, 1'b0);
        end
        $display("test low power over");
        sel_n = 1'b1;
        acc(mmp_pkg::IDX_CTRL, ~c, 1'b0, 1'b1);
        sel_n = 1'b0;
        acc(mmp_pkg::IDX_CTRL, c, 1'b1, 1'b0);
        $display("test select over");
        {fault, crit} = 2'b11;
        cyc(1);
        {fault, crit} = 2'b00;
        wt(1'b0);
        acc(mmp_pkg::IDX_FLAGS, 8'h06, 1'b1, 1'b0);
        wt(1'b1);
        acc(mmp_pkg::IDX_MASK, 8'h02, 1'b0, 1'b0);
        fault = 1'b1;
        cyc(1);
        fault = 1'b0;
        cyc(4);
        chk("masked irq", 8'h01, {7'h0, irq_oe_n});
        acc(mmp_pkg::IDX_FLAGS, 8'h02, 1'b1, 1'b0);
        $display("test fault over");
        acc(mmp_pkg::IDX_CTRL, 8'h01, 1'b0, 1'b0);
        rst_n = 1'b0;
        cyc(4);
        rst_n = 1'b1;
        acc(mmp_pkg::IDX_CTRL, 8'h01, 1'b1, 1'b0);
        rst_n = 1'b0;
        cyc(20);
        chk("settings reset", 8'h01, {7'h0, srst});
        rst_n = 1'b1;
        wt(1'b0);
        acc(mmp_pkg::IDX_CTRL, 8'h00, 1'b1, 1'b0);
        acc(mmp_pkg::IDX_MASK, 8'h00, 1'b1, 1'b0);
        $display("test pin reset over");
        give_verdict();
    end
endmodule
`default_nettype wire
